// >>> rtl/io_port.sv
`timescale 1ns/1ps
module io_port (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  // pins
  input  wire logic [io_port_pkg::PIN_COUNT-1:0] pin_in,
  output logic [io_port_pkg::PIN_COUNT-1:0]      pin_out,
  output logic [io_port_pkg::PIN_COUNT-1:0]      pin_oe_out,
  output logic [io_port_pkg::PIN_COUNT-1:0]      very_weak_up_out,
  output logic [io_port_pkg::PIN_COUNT-1:0]      weak_up_out,
  output logic [io_port_pkg::PIN_COUNT-1:0]      strong_up_out,
  output logic [io_port_pkg::PIN_COUNT-1:0]      pull_down_out
);
  import io_port_pkg::*;

  logic [PIN_COUNT-1:0] port_output_latch_reg;
  logic [PIN_COUNT-1:0] pin_mode_select_high_reg;
  logic [PIN_COUNT-1:0] pin_mode_select_low_reg;
  logic [PIN_COUNT-1:0] pin_level;
  logic                 answered_reg;
  logic [3:0]           select;
  logic                 access;

  // one wait cycle: the answer comes the edge after the request is seen
  assign access          = read_in | write_in;
  assign waitrequest_out = access & ~answered_reg;
  assign select          = reg_select(address_in);

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      answered_reg <= 1'b0;
    end else begin
      answered_reg <= access & ~answered_reg;
    end
  end

  // register writes take effect on the edge where waitrequest is low
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      port_output_latch_reg    <= LATCH_RESET;
      pin_mode_select_high_reg <= MODE_RESET;
      pin_mode_select_low_reg  <= MODE_RESET;
    end else if (write_in && answered_reg && byteenable_in[0]) begin
      if (select[0]) begin
        port_output_latch_reg <= writedata_in[PIN_COUNT-1:0];
      end
      if (select[1]) begin
        pin_mode_select_high_reg <= writedata_in[PIN_COUNT-1:0];
      end
      if (select[2]) begin
        pin_mode_select_low_reg <= writedata_in[PIN_COUNT-1:0];
      end
    end
  end

  // read data registered so it stands at the answering edge
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      readdata_out <= UNMAPPED_READ;
    end else if (read_in && !answered_reg) begin
      case (select)
        4'h1:    readdata_out <= {26'h0, port_output_latch_reg};
        4'h2:    readdata_out <= {26'h0, pin_mode_select_high_reg};
        4'h4:    readdata_out <= {26'h0, pin_mode_select_low_reg};
        4'h8:    readdata_out <= {26'h0, pin_level};
        default: readdata_out <= UNMAPPED_READ;
      endcase
    end
  end

  // per-pin input stage and driver; same input path in every mode
  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
    pin_input_sync u_sync (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .pin_in     (pin_in[n]),
      .level_out  (pin_level[n])
    );

    pin_driver u_drv (
      .clock_in         (clock_in),
      .reset_n_in       (reset_n_in),
      .mode_in          ({pin_mode_select_high_reg[n], pin_mode_select_low_reg[n]}),
      .latch_in         (port_output_latch_reg[n]),
      .level_in         (pin_level[n]),
      .very_weak_up_out (very_weak_up_out[n]),
      .weak_up_out      (weak_up_out[n]),
      .strong_up_out    (strong_up_out[n]),
      .pull_down_out    (pull_down_out[n])
    );

    // strong drivers decide the pad; weak pull-ups are reported only
    assign pin_oe_out[n] = strong_up_out[n] | pull_down_out[n];
    assign pin_out[n]    = strong_up_out[n];
  end

endmodule // io_port

// >>> rtl/io_port_pkg.sv
package io_port_pkg;

  // port geometry
  localparam int PIN_COUNT = 6;

  // register word addresses (byte addresses, one aligned word each)
  localparam logic [3:0] ADDR_OUTPUT_LATCH = 4'h0;
  localparam logic [3:0] ADDR_MODE_HIGH    = 4'h4;
  localparam logic [3:0] ADDR_MODE_LOW     = 4'h8;
  localparam logic [3:0] ADDR_PIN_LEVEL    = 4'hC;

  // values after reset
  localparam logic [5:0] LATCH_RESET = 6'h3F;
  localparam logic [5:0] MODE_RESET  = 6'h00;

  // strong pull-up pulse length in cpu clock cycles
  localparam int STRONG_PULSE_CYCLES = 2;
  localparam logic [1:0] STRONG_PULSE_LOAD = 2'(STRONG_PULSE_CYCLES);

  // pin mode encodings {high, low}
  localparam logic [1:0] MODE_QUASI     = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_INPUT     = 2'h2;
  localparam logic [1:0] MODE_OPEN      = 2'h3;

  // bus answer for unmapped reads
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // decode a register address into a one-hot select
  function automatic logic [3:0] reg_select(input logic [3:0] addr);
    reg_select = 4'h0;
    case (addr)
      ADDR_OUTPUT_LATCH: reg_select = 4'h1;
      ADDR_MODE_HIGH:    reg_select = 4'h2;
      ADDR_MODE_LOW:     reg_select = 4'h4;
      ADDR_PIN_LEVEL:    reg_select = 4'h8;
      default:           reg_select = 4'h0;
    endcase
  endfunction

endpackage

// >>> rtl/pin_driver.sv
`timescale 1ns/1ps
// per-pin driver selection from mode, latch and sampled level
module pin_driver (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       latch_in,
  input  wire logic       level_in,
  output logic            very_weak_up_out,
  output logic            weak_up_out,
  output logic            strong_up_out,
  output logic            pull_down_out
);
  import io_port_pkg::*;

  logic       latch_prev_reg;
  logic [1:0] pulse_count_reg;
  logic       quasi;

  assign quasi = (mode_in == MODE_QUASI);

  // remember latch to spot a 0 to 1 rise
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      latch_prev_reg <= 1'b1;
    end else begin
      latch_prev_reg <= latch_in;
    end
  end

  // strong pulse counter; a mode change away from quasi cuts it short
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pulse_count_reg <= 2'h0;
    end else if (!quasi || !latch_in) begin
      pulse_count_reg <= 2'h0;
    end else if (!latch_prev_reg) begin
      pulse_count_reg <= STRONG_PULSE_LOAD;
    end else if (pulse_count_reg != 2'h0) begin
      pulse_count_reg <= pulse_count_reg - 2'h1;
    end
  end

  // driver selection per mode
  always_comb begin
    very_weak_up_out = 1'b0;
    weak_up_out      = 1'b0;
    strong_up_out    = 1'b0;
    pull_down_out    = 1'b0;
    case (mode_in)
      MODE_QUASI: begin
        very_weak_up_out = latch_in;
        weak_up_out      = latch_in & level_in;
        strong_up_out    = (pulse_count_reg != 2'h0);
        pull_down_out    = ~latch_in;
      end
      MODE_PUSH_PULL: begin
        strong_up_out = latch_in;
        pull_down_out = ~latch_in;
      end
      MODE_INPUT: begin
        pull_down_out = 1'b0;
      end
      MODE_OPEN: begin
        pull_down_out = ~latch_in;
      end
      default: begin
        pull_down_out = 1'b0;
      end
    endcase
  end

endmodule // pin_driver

// >>> rtl/pin_input_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter for one pin
module pin_input_sync (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic pin_in,
  output logic      level_out
);
  import io_port_pkg::*;

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // shift chain; first stage only feeds the second
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
      stage3_reg <= 1'b1;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // level changes only once stages two and three agree
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      level_out <= 1'b1;
    end else if (stage2_reg == stage3_reg) begin
      level_out <= stage3_reg;
    end
  end

endmodule // pin_input_sync

// >>> verification/configurable_io_port_pins_tb.sv
`timescale 1ns/1ps
// reset reads and byte-enable check first, then the mode table, then the strong pulse cases
module configurable_io_port_pins_tb;
  import io_port_pkg::*;
  logic            clock_in = 1'b0;
  logic            reset_n_in = 1'b0;
  logic [3:0]      address_in = 4'h0;
  logic            read_in = 1'b0;
  logic            write_in = 1'b0;
  logic [31:0]     writedata_in = 32'h0;
  logic [3:0]      byteenable_in = 4'hF;
  logic [31:0]     readdata_out, rd;
  logic            waitrequest_out;
  logic [5:0]      pin_in, pin_out, pin_oe_out, very_weak_up_out, weak_up_out, strong_up_out;
  logic [5:0]      pull_down_out, sink = 6'h00, ext_up = 6'h00;
  int              fail_count = 0, samples_checked = 0, hits = 0, h0;
  // {mode high, mode low, latch, sink, ext up | very weak, weak, strong, down, level}
  logic [9:0][7:0] rows [7] = '{80'h00_00_3F_00_00_3F_3F_00_00_3F,
    80'h00_00_3F_05_00_3F_3A_00_00_3A, 80'h00_00_0F_00_00_0F_0F_00_30_0F,
    80'h00_3F_0F_3F_00_00_00_0F_30_0F, 80'h3F_00_0F_03_30_00_00_00_00_30,
    80'h3F_3F_0F_01_3F_00_00_00_30_0E, 80'h0C_2A_15_00_00_11_11_00_2A_11};

  io_port uut (.*);
  pin_load_model load (.drive_in(pin_out), .oe_in(pin_oe_out), .sink_in(sink),
    .pull_in(very_weak_up_out | weak_up_out), .ext_up_in(ext_up), .pad_out(pin_in));

  initial forever #50 clock_in = ~clock_in;
  // edges with all six strong pull-ups on
  always @(posedge clock_in) hits <= hits + int'(strong_up_out == 6'h3F);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one access held until waitrequest is seen low, then released a cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address_in   <= a;
    writedata_in <= d;
    write_in     <= w;
    read_in      <= !w;
    @(posedge clock_in);
    while (waitrequest_out !== 1'b0) begin
      n++;
      if (n > 20) begin
        fail_count++;
        tally_and_finish();
      end
      @(posedge clock_in);
    end
    rd = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
    @(posedge clock_in);
  endtask

  initial begin
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    bus(0, ADDR_OUTPUT_LATCH, 32'h0);
    chk(rd[7:0], 8'h3F);
    bus(0, ADDR_MODE_LOW, 32'h0);
    chk(rd[7:0], 8'h00);
    bus(0, 4'h2, 32'h0);
    chk(rd[7:0], 8'h00);
    byteenable_in <= 4'hE;
    bus(1, ADDR_MODE_HIGH, 32'h3F);
    byteenable_in <= 4'hF;
    bus(0, ADDR_MODE_HIGH, 32'h0);
    chk(rd[7:0], 8'h00);
    foreach (rows[i]) begin
      sink   <= rows[i][6][5:0];
      ext_up <= rows[i][5][5:0];
      bus(1, ADDR_MODE_HIGH, 32'(rows[i][9]));
      bus(1, ADDR_MODE_LOW, 32'(rows[i][8]));
      bus(1, ADDR_OUTPUT_LATCH, 32'(rows[i][7]));
      repeat (8) @(posedge clock_in);
      chk(8'(very_weak_up_out), rows[i][4]);
      chk(8'(weak_up_out), rows[i][3]);
      chk(8'(strong_up_out), rows[i][2]);
      chk(8'(pull_down_out), rows[i][1]);
      bus(0, ADDR_PIN_LEVEL, 32'h0);
      chk(rd[7:0], rows[i][0]);
    end
    // latch rise in quasi, then in input-only where no pulse may come
    for (int m = 0; m < 2; m++) begin
      bus(1, ADDR_MODE_HIGH, m ? 32'h3F : 32'h0);
      bus(1, ADDR_MODE_LOW, 32'h0);
      bus(1, ADDR_OUTPUT_LATCH, 32'h0);
      h0 = hits;
      bus(1, ADDR_OUTPUT_LATCH, 32'h3F);
      repeat (6) @(posedge clock_in);
      chk(8'(hits - h0), m ? 8'h00 : 8'h02);
    end
    tally_and_finish();
  end
endmodule // configurable_io_port_pins_tb

// >>> verification/io_port_properties.sv
`timescale 1ns/1ps
// driver relations of the port, judged from its pins and driver outputs only
module io_port_properties #(
  parameter int N = io_port_pkg::PIN_COUNT
) (
  input wire logic         clock_in,
  input wire logic         reset_n_in,
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe_out,
  input wire logic [N-1:0] very_weak_up_out,
  input wire logic [N-1:0] weak_up_out,
  input wire logic [N-1:0] strong_up_out,
  input wire logic [N-1:0] pull_down_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // very weak pull-up marks quasi with latch 1, so push-pull is excluded
  sequence two_high_s;
    strong_up_out[0] ##1 !strong_up_out[0];
  endsequence
  reset_state_a: assert property ($rose(reset_n_in) |-> very_weak_up_out == '1 &&
    pull_down_out == '0 && strong_up_out == '0) else $error("port not quasi after reset");
  pulse_two_a: assert property ($rose(strong_up_out[0]) && very_weak_up_out[0] |=> two_high_s)
    else $error("strong pulse width wrong");
  drive_excl_a: assert property ((strong_up_out & pull_down_out) == '0)
    else $error("strong up and pull-down together");
  oe_cover_a: assert property (pin_oe_out == (strong_up_out | pull_down_out))
    else $error("enable does not match strong drivers");
  pin_high_a: assert property (pin_out == strong_up_out)
    else $error("pin value differs from strong pull-up");
  weak_gate_a: assert property ((weak_up_out & ~very_weak_up_out) == '0)
    else $error("weak pull-up without latch 1");
  up_down_excl_a: assert property (((very_weak_up_out | weak_up_out) & pull_down_out) == '0)
    else $error("pull-up on while pulling down");
  // the filtered level lags the pad by a few edges
  weak_drop_a: assert property ($fell(pin_in[0]) && !pin_oe_out[0] |-> ##[1:6] !weak_up_out[0])
    else $error("weak pull-up kept on a low pin");
endmodule // io_port_properties

bind io_port io_port_properties chk (.*);

// >>> verification/pin_load_model.sv
`timescale 1ns/1ps
// board side of the pads: an external sink, pull resistors
module pin_load_model #(
  parameter int N = io_port_pkg::PIN_COUNT
) (
  input  wire logic [N-1:0] drive_in,
  input  wire logic [N-1:0] oe_in,
  input  wire logic [N-1:0] pull_in,   // very weak or weak internal pull-up on
  input  wire logic [N-1:0] sink_in,   // external device pulling low
  input  wire logic [N-1:0] ext_up_in, // external pull-up fitted
  output logic      [N-1:0] pad_out
);
  // port drivers win; an unpulled pad sits on a board pull-down, never floats
  assign pad_out = (oe_in & drive_in) | (~oe_in & ~sink_in & (pull_in | ext_up_in));
endmodule // pin_load_model
